/* File: rtl/setup_fetch.v */
// Purpose: Fetch motor, serial and CAN setup words after reset and hold the configuration
// Assumes: Board buffers drive setup words only while strobe and select are low and the address bit is high
// Notes:   Setup words are passed on undecoded; field encoding lives downstream
//
// The register offsets and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "setup_fetch_defs.vh"

module setup_fetch #(
	parameter [19:0] INIT_LIMIT_CYCLES   = `INIT_LIMIT_CYC,  // Init deadline
	parameter [19:0] DEFAULT_BYTE_CYCLES = `BYTE_TIME_CYC,   // Byte time at default baud
	parameter [15:0] SERIAL_DEFAULT_MODE = 16'h0000,         // Encoded 57600 8N1 point-to-point
	parameter [15:0] CAN_DEFAULT_MODE    = 16'h0000          // Encoded 20 kbps, node id 0
) (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	output reg  [15:0] ext_addr,
	output reg         bus_read_strobe_n,
	output reg         peripheral_space_select_n,
	input  wire [15:0] ext_data_in,
	output wire [15:0] ext_data_out,
	output wire        ext_data_oe,
	input  wire        host_cmd_end,
	output wire        response_allowed,
	output reg         init_done,
	output reg  [15:0] motor_setup_word,
	output reg  [15:0] serial_mode_word,
	output reg  [15:0] can_mode_word,
	output reg         serial_using_default,
	output reg         can_using_default
);

	// Fetch sequencer states
	localparam [2:0] S_START  = 3'h0;
	localparam [2:0] S_STROBE = 3'h1;
	localparam [2:0] S_SETTLE = 3'h2;
	localparam [2:0] S_GAP    = 3'h3;
	localparam [2:0] S_DONE   = 3'h4;

	reg  [2:0]  state_q;         // Sequencer state
	reg  [1:0]  word_idx_q;      // 0 motor, 1 serial, 2 CAN
	reg  [3:0]  hold_cnt_q;      // Strobe hold counter
	reg  [19:0] init_cnt_q;      // Cycles since release or restart
	reg  [15:0] data_s1_q;       // Pin synchroniser, first stage
	reg  [15:0] data_s2_q;       // Second stage
	reg  [15:0] data_s3_q;       // Third stage
	reg  [15:0] raw_serial_q;    // Serial word as read from the bus
	reg  [15:0] raw_can_q;       // CAN word as read from the bus
	reg         half_duplex_q;   // Control: shared line operation
	reg         restart_q;       // Control: one-cycle refetch request
	reg  [19:0] byte_time_q;     // Byte time in clock cycles
	reg  [19:0] resp_cnt_q;      // Turnaround counter
	reg         resp_wait_q;     // Turnaround in progress
	reg         ap_write_q;      // Data phase is a write
	reg  [7:0]  ap_addr_q;       // Latched register offset
	wire        data_stable;     // Second and third stage agree
	wire        ap_take;         // Address phase accepted
	wire        init_timeout;    // Deadline reached without finishing
	reg  [15:0] cur_addr;        // Address of the word being fetched
	reg  [31:0] rd_mux;          // Register read data

	// The device never drives the data bus while fetching; the pad
	// pull-ups make an unbuffered read return all ones
	assign ext_data_out = 16'h0000;
	assign ext_data_oe  = 1'b0;

	// Two later stages agree before a word is trusted
	assign data_stable  = (data_s2_q == data_s3_q);
	assign init_timeout = (init_cnt_q >= INIT_LIMIT_CYCLES) && !init_done;

	// Zero wait-state slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign ap_take   = hsel && htrans[1] && hready;

	// Each word owns one dedicated address line
	always @* begin
		case (word_idx_q)
			2'd0:    cur_addr = `PADDR_MOTOR;
			2'd1:    cur_addr = `PADDR_SERIAL;
			2'd2:    cur_addr = `PADDR_CAN;
			default: cur_addr = `PADDR_MOTOR;
		endcase
	end

	// Data bus synchroniser; first stage feeds only the second
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_s1_q <= 16'h0000;
			data_s2_q <= 16'h0000;
			data_s3_q <= 16'h0000;
		end else begin
			data_s1_q <= ext_data_in;
			data_s2_q <= data_s1_q;
			data_s3_q <= data_s2_q;
		end
	end

	// Fetch sequencer: three peripheral reads after reset or restart
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q                   <= S_START;
			word_idx_q                <= 2'd0;
			hold_cnt_q                <= 4'h0;
			init_cnt_q                <= 20'h00000;
			ext_addr                  <= 16'h0000;
			bus_read_strobe_n         <= 1'b1;
			peripheral_space_select_n <= 1'b1;
			init_done                 <= 1'b0;
			motor_setup_word          <= 16'h0000;
			raw_serial_q              <= `SETUP_DEFAULT_WORD;
			raw_can_q                 <= `SETUP_DEFAULT_WORD;
		end else if (restart_q) begin
			// Software refetch reruns the whole sequence
			state_q                   <= S_START;
			word_idx_q                <= 2'd0;
			init_cnt_q                <= 20'h00000;
			init_done                 <= 1'b0;
			bus_read_strobe_n         <= 1'b1;
			peripheral_space_select_n <= 1'b1;
		end else if (init_timeout) begin
			// Deadline guard: whatever was not read keeps its last value (the defaults after a reset)
			state_q                   <= S_DONE;
			init_done                 <= 1'b1;
			bus_read_strobe_n         <= 1'b1;
			peripheral_space_select_n <= 1'b1;
		end else begin
			if (!init_done) begin
				init_cnt_q <= init_cnt_q + 20'h00001;
			end
			case (state_q)
				S_START: begin
					// Present address and select, open the read
					ext_addr                  <= cur_addr;
					peripheral_space_select_n <= 1'b0;
					bus_read_strobe_n         <= 1'b0;
					hold_cnt_q                <= `READ_HOLD_CYC;
					state_q                   <= S_STROBE;
				end
				S_STROBE: begin
					// Give the board buffer and synchroniser time
					if (hold_cnt_q == 4'h0) begin
						state_q <= S_SETTLE;
					end else begin
						hold_cnt_q <= hold_cnt_q - 4'h1;
					end
				end
				S_SETTLE: begin
					// Capture only a word that has stopped moving
					if (data_stable) begin
						case (word_idx_q)
							2'd0:    motor_setup_word <= data_s3_q;
							2'd1:    raw_serial_q     <= data_s3_q;
							default: raw_can_q        <= data_s3_q;
						endcase
						bus_read_strobe_n         <= 1'b1;
						peripheral_space_select_n <= 1'b1;
						state_q                   <= S_GAP;
					end
				end
				S_GAP: begin
					// One idle cycle so buffers release before the next read
					if (word_idx_q == 2'd2) begin
						init_done <= 1'b1;
						state_q   <= S_DONE;
					end else begin
						word_idx_q <= word_idx_q + 2'd1;
						state_q    <= S_START;
					end
				end
				S_DONE: begin
					state_q <= S_DONE;
				end
				default: begin
					state_q <= S_START;
				end
			endcase
		end
	end

	// Effective configuration: boot words, then run-time mode commands
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_mode_word     <= SERIAL_DEFAULT_MODE;
			can_mode_word        <= CAN_DEFAULT_MODE;
			serial_using_default <= 1'b1;
			can_using_default    <= 1'b1;
		end else if (state_q == S_GAP && word_idx_q == 2'd1) begin
			if (raw_serial_q == `SETUP_DEFAULT_WORD) begin
				serial_mode_word     <= SERIAL_DEFAULT_MODE;
				serial_using_default <= 1'b1;
			end else begin
				serial_mode_word     <= raw_serial_q;
				serial_using_default <= 1'b0;
			end
		end else if (state_q == S_GAP && word_idx_q == 2'd2) begin
			if (raw_can_q == `SETUP_DEFAULT_WORD) begin
				can_mode_word     <= CAN_DEFAULT_MODE;
				can_using_default <= 1'b1;
			end else begin
				can_mode_word     <= raw_can_q;
				can_using_default <= 1'b0;
			end
		end else if (ap_write_q && init_done) begin
			// Mode-setting commands only once the link is up
			if (ap_addr_q == `REG_SERIAL_MODE) begin
				serial_mode_word     <= hwdata[15:0];
				serial_using_default <= 1'b0;
			end
			if (ap_addr_q == `REG_CAN_MODE) begin
				can_mode_word     <= hwdata[15:0];
				can_using_default <= 1'b0;
			end
		end
	end

	// Half-duplex turnaround: hold off replies for one byte time
	assign response_allowed = !half_duplex_q || !resp_wait_q;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_cnt_q  <= 20'h00000;
			resp_wait_q <= 1'b0;
		end else if (host_cmd_end) begin
			// Each command end restarts the wait, relying on the host
			// to have freed the line by the time it runs out
			resp_cnt_q  <= 20'h00000;
			resp_wait_q <= 1'b1;
		end else if (resp_wait_q) begin
			if (resp_cnt_q + 20'h00001 >= byte_time_q) begin
				resp_wait_q <= 1'b0;
			end
			resp_cnt_q <= resp_cnt_q + 20'h00001;
		end
	end

	// AHB-Lite address phase capture
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_write_q <= 1'b0;
			ap_addr_q  <= 8'h00;
		end else if (hready) begin
			ap_write_q <= ap_take && hwrite;
			ap_addr_q  <= haddr[7:0];
		end
	end

	// Control and byte-time registers; restart bit self-clears
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_duplex_q <= 1'b0;
			restart_q     <= 1'b0;
			byte_time_q   <= DEFAULT_BYTE_CYCLES;
		end else begin
			restart_q <= 1'b0;
			if (ap_write_q && ap_addr_q == `REG_CONTROL) begin
				half_duplex_q <= hwdata[`CTL_HALF_DUPLEX];
				restart_q     <= hwdata[`CTL_RESTART];
			end
			// A zero byte time is stored as one; either value holds the line one cycle
			if (ap_write_q && ap_addr_q == `REG_BYTE_TIME) begin
				byte_time_q <= (hwdata[19:0] == 20'h00000) ? 20'h00001 : hwdata[19:0];
			end
		end
	end

	// Register read multiplexer; unmapped offsets read zero
	always @* begin
		rd_mux = 32'h00000000;
		case (haddr[7:0])
			`REG_STATUS: begin
				rd_mux[`ST_INIT_DONE]      = init_done;
				rd_mux[`ST_SERIAL_DEFAULT] = serial_using_default;
				rd_mux[`ST_CAN_DEFAULT]    = can_using_default;
				rd_mux[`ST_RESP_ALLOWED]   = response_allowed;
			end
			`REG_CONTROL:     rd_mux[`CTL_HALF_DUPLEX] = half_duplex_q;
			`REG_MOTOR_SETUP: rd_mux[15:0] = motor_setup_word;
			`REG_SERIAL_MODE: rd_mux[15:0] = serial_mode_word;
			`REG_CAN_MODE:    rd_mux[15:0] = can_mode_word;
			`REG_BYTE_TIME:   rd_mux[19:0] = byte_time_q;
			`REG_RAW_SERIAL:  rd_mux[15:0] = raw_serial_q;
			`REG_RAW_CAN:     rd_mux[15:0] = raw_can_q;
			default:          rd_mux = 32'h00000000;
		endcase
	end

	// Read data registered at the address phase, stands in the data phase
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ap_take && !hwrite) begin
			hrdata <= rd_mux;
		end
	end

endmodule
`default_nettype wire

/* File: shared/setup_fetch_defs.vh */
// Purpose: Constants for the power-up setup word fetch block
// Assumes: 50 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   Definitions only; included by bare name
`ifndef SETUP_FETCH_DEFS_VH
`define SETUP_FETCH_DEFS_VH

// Clock and timing figures in their own units
`define CLK_HZ              50000000
`define CLK_MHZ             50
`define INIT_TIME_US        1500
`define SERIAL_DEFAULT_BAUD 57600
`define BITS_PER_BYTE       10
// Sized to the 20-bit counters: 1500 us at 50 MHz, and a ten-bit
// byte at the default baud rounded up so the turnaround is never short
`define INIT_LIMIT_CYC      20'h124F8
`define BYTE_TIME_CYC       20'h21E9
// Strobe hold per external read, covers 30 ns buffer path plus sync
`define READ_HOLD_CYC       4'h6

// Peripheral addresses of the three setup words
`define PADDR_MOTOR         16'h0100
`define PADDR_SERIAL        16'h0200
`define PADDR_CAN           16'h0400
`define SETUP_DEFAULT_WORD  16'hFFFF

// Register byte offsets
`define REG_STATUS          8'h00
`define REG_CONTROL         8'h04
`define REG_MOTOR_SETUP     8'h08
`define REG_SERIAL_MODE     8'h0C
`define REG_CAN_MODE        8'h10
`define REG_BYTE_TIME       8'h14
`define REG_RAW_SERIAL      8'h18
`define REG_RAW_CAN         8'h1C

// Field positions
`define ST_INIT_DONE        0
`define ST_SERIAL_DEFAULT   1
`define ST_CAN_DEFAULT      2
`define ST_RESP_ALLOWED     3
`define CTL_HALF_DUPLEX     0
`define CTL_RESTART         1
`define CONTROL_RESET       2'h0
`endif

/* File: sim/setup_fetch_sva.sv */
// Purpose: Port assertions for the setup word fetch
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every setup_fetch instance
`timescale 1ns/100ps
`default_nettype none
module setup_fetch_sva #(
	parameter [19:0] INIT_LIMIT_CYCLES = 20'h124F8 // Init deadline in cycles
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic [15:0] ext_addr,
	input wire logic        bus_read_strobe_n,
	input wire logic        peripheral_space_select_n,
	input wire logic        ext_data_oe,
	input wire logic        host_cmd_end,
	input wire logic        response_allowed,
	input wire logic        init_done,
	input wire logic [15:0] serial_mode_word,
	input wire logic        serial_using_default
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [19:0] wait_q; // Cycles spent without init_done
	// One cycle of slack covers the done flop itself
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) wait_q <= 20'h0;
		else if (init_done) wait_q <= 20'h0;
		else wait_q <= wait_q + 20'h1;
	end
	AST_DEADLINE: assert property (wait_q <= INIT_LIMIT_CYCLES + 20'h1)
		else $error("init not done in time");
	AST_FIRST_READ: assert property ($rose(hresetn) |=> !bus_read_strobe_n && ext_addr == 16'h0100)
		else $error("first read not at motor word");
	AST_ORDER: assert property ($changed(ext_addr) && ext_addr != 16'h0100 |-> ext_addr == {$past(ext_addr[14:0]), 1'b0})
		else $error("setup reads out of order");
	AST_ADDR_BITS: assert property (!bus_read_strobe_n |-> ext_addr inside {16'h0100, 16'h0200, 16'h0400})
		else $error("read at a non-setup address");
	AST_SELECT: assert property (bus_read_strobe_n == peripheral_space_select_n)
		else $error("select and strobe differ");
	AST_HOLD: assert property ($fell(bus_read_strobe_n) |=> (!bus_read_strobe_n && $stable(ext_addr))[*6])
		else $error("read strobe too short");
	AST_NO_DRIVE: assert property (!ext_data_oe)
		else $error("device drives the data bus");
	AST_IDLE_DONE: assert property (init_done |-> bus_read_strobe_n)
		else $error("read after init done");
	AST_DEFAULT: assert property (init_done && serial_using_default |-> serial_mode_word == 16'h0000)
		else $error("serial default word wrong");
	AST_RESP: assert property ($fell(response_allowed) |-> $past(host_cmd_end))
		else $error("response blocked without a command end");
endmodule
bind setup_fetch setup_fetch_sva #(.INIT_LIMIT_CYCLES(INIT_LIMIT_CYCLES)) sva_u (
	.hclk(hclk), .hresetn(hresetn), .ext_addr(ext_addr), .bus_read_strobe_n(bus_read_strobe_n),
	.peripheral_space_select_n(peripheral_space_select_n), .ext_data_oe(ext_data_oe),
	.host_cmd_end(host_cmd_end), .response_allowed(response_allowed), .init_done(init_done),
	.serial_mode_word(serial_mode_word), .serial_using_default(serial_using_default));
`default_nettype wire

/* File: sim/board_buffers.sv */
// Purpose: Board switches behind tri-state buffers on the data bus
// Assumes: Pull-ups hold a released bus at all ones
// Notes:   fitted low models a board without setup circuitry
`timescale 1ns/100ps
`default_nettype none
module board_buffers (
	input wire logic [15:0] ext_addr,
	input wire logic        bus_read_strobe_n,
	input wire logic        peripheral_space_select_n,
	input wire logic        fitted,
	input wire logic [15:0] motor_word,
	input wire logic [15:0] serial_word,
	input wire logic [15:0] can_word,
	output logic     [15:0] ext_data_in
);
	logic serial_setup_buffer_enable_n; // Low while serial word drives
	logic can_setup_buffer_enable_n;    // Low while CAN word drives
	logic motor_enable_n;               // Low while motor word drives
	assign serial_setup_buffer_enable_n = bus_read_strobe_n | peripheral_space_select_n | ~ext_addr[9];
	assign can_setup_buffer_enable_n = bus_read_strobe_n | peripheral_space_select_n | ~ext_addr[10];
	assign motor_enable_n = bus_read_strobe_n | peripheral_space_select_n | ~ext_addr[8];
	// Any bus nobody drives floats up, so stale words never linger
	always_comb begin
		if (!fitted) ext_data_in = 16'hFFFF;
		else if (!serial_setup_buffer_enable_n) ext_data_in = serial_word;
		else if (!can_setup_buffer_enable_n) ext_data_in = can_word;
		else if (!motor_enable_n) ext_data_in = motor_word;
		else ext_data_in = 16'hFFFF;
	end
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the setup word fetch
// Assumes: Short init deadline and byte time through parameters
// Notes:   Random setup words from a fixed xorshift seed
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, fitted;
	logic        host_cmd_end, response_allowed, init_done, ext_data_oe;
	logic        bus_read_strobe_n, peripheral_space_select_n;
	logic        serial_using_default, can_using_default;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd, seed;
	logic [15:0] ext_addr, ext_data_in, ext_data_out, motor_word, serial_word, can_word;
	logic [15:0] motor_setup_word, serial_mode_word, can_mode_word;
	int          n_fail, n_tests, n;
	assign hready = hreadyout; // Single slave drives the bus ready
	setup_fetch #(.INIT_LIMIT_CYCLES(20'hC8), .DEFAULT_BYTE_CYCLES(20'h14)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_addr(ext_addr),
		.bus_read_strobe_n(bus_read_strobe_n), .peripheral_space_select_n(peripheral_space_select_n),
		.ext_data_in(ext_data_in), .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
		.host_cmd_end(host_cmd_end), .response_allowed(response_allowed), .init_done(init_done),
		.motor_setup_word(motor_setup_word), .serial_mode_word(serial_mode_word),
		.can_mode_word(can_mode_word), .serial_using_default(serial_using_default),
		.can_using_default(can_using_default));
	board_buffers board_u (.ext_addr(ext_addr), .bus_read_strobe_n(bus_read_strobe_n),
		.peripheral_space_select_n(peripheral_space_select_n), .fitted(fitted),
		.motor_word(motor_word), .serial_word(serial_word), .can_word(can_word),
		.ext_data_in(ext_data_in));
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	function logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		x = x ^ (x << 5);
		return x;
	endfunction
	// All ones selects the default mode word
	function logic [15:0] exp_mode(input logic [15:0] w);
		return (w === 16'hFFFF) ? 16'h0000 : w;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Single word transfer; the wait only ends on hready
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	// Pulse command end, then count cycles with the response held off
	task cmd(output int cnt);
		host_cmd_end <= 1'b1;
		@(posedge hclk);
		host_cmd_end <= 1'b0;
		cnt = 0;
		repeat (30) begin
			@(posedge hclk);
			#1;
			cnt += (response_allowed !== 1'b1);
		end
		@(posedge hclk);
	endtask
	task test_done;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge hclk);
		n_fail++;
		test_done;
	end
	initial begin
		hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2;
		haddr = 32'h0; hwdata = 32'h0; host_cmd_end = 1'b0; fitted = 1'b0;
		motor_word = 16'hFFFF; serial_word = 16'hFFFF; can_word = 16'hFFFF;
		seed = 32'h5CFAE741; n_fail = 0; n_tests = 0;
		// Pass 0 has no board circuitry, pass 1 a driven all-ones CAN word
		for (int i = 0; i < 4; i++) begin
			if (i > 0) begin
				seed = xs(seed);
				fitted <= 1'b1;
				motor_word <= seed[31:16];
				serial_word <= seed[15:0];
				seed = xs(seed);
				can_word <= (i == 1) ? 16'hFFFF : seed[15:0];
			end
			hresetn <= 1'b0;
			repeat (6) @(posedge hclk);
			hresetn <= 1'b1;
			bus(1'b1, 8'h0C, 32'h1234, rd); // Refused while init runs
			bus(1'b0, 8'h0C, 32'h0, rd);
			chk(rd, {16'h0, exp_mode(16'hFFFF)});
			n = 0;
			while (init_done !== 1'b1) begin
				@(posedge hclk);
				n++;
			end
			chk(n <= 200, 1);
			chk(serial_mode_word, exp_mode(serial_word));
			chk(can_mode_word, exp_mode(can_word));
			chk(motor_setup_word, motor_word);
			chk(can_using_default, can_word === 16'hFFFF);
			bus(1'b0, 8'h00, 32'h0, rd);
			chk(rd, {28'h1, can_word === 16'hFFFF, serial_word === 16'hFFFF, 1'b1});
			bus(1'b0, 8'h18, 32'h0, rd);
			chk(rd, {16'h0, serial_word});
			bus(1'b0, 8'h1C, 32'h0, rd);
			chk(rd, {16'h0, can_word});
			$display("fetch test %0d done", i);
		end
		seed = xs(seed);
		bus(1'b1, 8'h0C, {16'h0, seed[15:0]}, rd);
		bus(1'b1, 8'h10, {16'h0, seed[31:16]}, rd);
		bus(1'b0, 8'h0C, 32'h0, rd);
		chk(rd, {16'h0, seed[15:0]});
		chk({serial_using_default, serial_mode_word}, {1'b0, seed[15:0]});
		chk({can_using_default, can_mode_word}, {1'b0, seed[31:16]});
		bus(1'b0, 8'h40, 32'h0, rd);
		chk(rd, 32'h0);
		$display("mode test done");
		// Software refetch: boot words replace the run-time mode words
		bus(1'b1, 8'h04, 32'h2, rd);
		repeat (2) @(posedge hclk);
		chk(init_done, 1'b0);
		while (init_done !== 1'b1) @(posedge hclk);
		chk(serial_mode_word, exp_mode(serial_word));
		chk(can_mode_word, exp_mode(can_word));
		$display("restart test done");
		bus(1'b1, 8'h14, 32'h14, rd);
		bus(1'b1, 8'h04, 32'h1, rd);
		cmd(n);
		chk(n >= 19 && n <= 21, 1);
		bus(1'b1, 8'h04, 32'h0, rd);
		cmd(n);
		chk(n, 0);
		$display("turnaround test done");
		test_done;
	end
endmodule
`default_nettype wire
